// [rtl/obcd_pkg.sv]
// obcd_pkg: constants for the option byte configuration decoder.
// assumes one 40 MHz system clock; obcd_decoder and the bench import this package.
package obcd_pkg;
  // programming port map, byte wide
  localparam logic [1:0] ADDR_OPT0 = 2'h0;
  localparam logic [1:0] ADDR_OPT1 = 2'h1;
  localparam logic [1:0] ADDR_CMD = 2'h2;
  localparam logic [1:0] ADDR_STAT = 2'h3;
  // command and status bit positions
  localparam int CMD_ERASE_OPT = 0;
  localparam int CMD_ERASE_MEM = 1;
  localparam int STAT_BUSY = 0;
  localparam int STAT_REFUSED = 1;
  localparam int STAT_MEM_CLEAN = 2;
  localparam int STAT_MISUSE = 3;
  // byte values
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] SHIP_OPT0 = 8'hFC;
  localparam logic [7:0] SHIP_OPT1 = 8'hEF;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  // option byte 0 fields
  localparam int B0_HALT_RST = 7;
  localparam int B0_DOG_SW = 6;
  localparam int B0_VD_LO = 4;
  localparam int B0_SEC_LO = 2;
  localparam int B0_RDLOCK = 1;
  localparam int B0_WRLOCK = 0;
  // option byte 1 fields
  localparam int B1_IRQ_MAP = 7;
  localparam int B1_GUARD = 6;
  localparam int B1_SRC_LO = 4;
  localparam int B1_BAND_LO = 1;
  localparam int B1_DOUBLER = 0;
  // smallest first block, in bytes
  localparam logic [12:0] BLOCK_BASE = 13'h0200;
  // supply detection codes
  typedef enum logic [1:0] {
    VD_HIGH = 2'b00,
    VD_MED = 2'b01,
    VD_LOW = 2'b10,
    VD_OFF = 2'b11
  } obcd_vd_t;
  // clock source codes
  typedef enum logic [1:0] {
    SRC_RESONATOR = 2'b00,
    SRC_RESERVED = 2'b01,
    SRC_RC = 2'b10,
    SRC_EXTERNAL = 2'b11
  } obcd_src_t;
  localparam logic [2:0] BAND_MP = 3'h1;
  // erase sequencer
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MEM_ERASE = 2'b01,
    ST_OPT_ERASE = 2'b10
  } obcd_state_t;
endpackage

// [rtl/obcd_sync3.sv]
// obcd_sync3: three flop synchroniser for pin levels.
// assumes the input is asynchronous to clk_sys; the output moves
// only once the second and third stages agree.
`timescale 1ns/10ps
module obcd_sync3 #(
  parameter logic RESET_VAL = 1'b0
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ce,
  // level in and out
  input wire logic pin,
  output logic level
);
  logic s1;
  logic s2;
  logic s3;
  // s1 feeds s2 only, to keep metastability out of the compare
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s1 <= RESET_VAL;
      s2 <= RESET_VAL;
      s3 <= RESET_VAL;
      level <= RESET_VAL;
    end else if (ce) begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level <= s3;
      end
    end
  end
endmodule

// [rtl/obcd_opt_cell.sv]
// obcd_opt_cell: one stored option byte with a registered read port.
// assumes the caller has already decided that a write is allowed.
`timescale 1ns/10ps
module obcd_opt_cell #(
  parameter logic [7:0] RESET_VAL = 8'hFF,
  parameter logic FIXED = 1'b0
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ce,
  // write side
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  // read side
  output logic [7:0] rd_data
);
  logic [7:0] store;
  // a fixed cell ignores writes: its value is part of the mask
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      store <= RESET_VAL;
    end else if (ce && wr_en && !FIXED) begin
      store <= wr_data;
    end
  end
  // read data always comes out of a register
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rd_data <= RESET_VAL;
    end else if (ce) begin
      rd_data <= store;
    end
  end
endmodule

// [rtl/obcd_decoder.sv]
// obcd_decoder: stores and decodes the two option bytes.
// assumes a programming tool on the byte port and a flash array
// controller on clk_sys that answers erase requests.
//
// Notes on behaviour
// R1 - option bytes have no address; reachable only in programming mode
// R2 - erased program memory cells read FFh
// R3 - option 0 bit 7 set: halt entry with watchdog active resets
// R4 - option 0 bit 6 clear keeps watchdog always on by hardware
// R5 - option 0 bits 5:4: 11 off, else low, medium, high threshold
// R6 - option 0 bits 3:2 give first block 0.5, 1, 2 or 4 KB
// R7 - option 0 bit 1 blocks memory access outside user and IN_APP_PROGRAMMING mode
// R8 - erasing options under read lock erases whole memory first
// R9 - option 0 bit 0 refuses every later erase or program for good; reset reloads SHIP_OPT0 here, which clears it
// R10 - option 1 bit 7 maps port C irq lines to vector b or a
// R11 - option 1 bit 6 clear enables clock guard
// R12 - option 1 bits 5:4 select resonator, reserved, RC or external
// R13 - option 1 bits 3:1: 1xx very low power, else four bands
// R14 - option 1 bit 0 clear enables clock doubler
// R15 - tool enables doubler only off RC and in 2 to 4 MHz band
// R16 - programmable parts ship with RC oscillator selected
// R17 - mask parts have option values fixed in hardware
// R18 - fields sampled at reset and programming exit, then held
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/10ps
module obcd_decoder
  import obcd_pkg::*;
#(
  parameter logic MASK_ROM = 1'b0,
  parameter logic [7:0] MASK_OPT0 = 8'hFC,
  parameter logic [7:0] MASK_OPT1 = 8'hEF
) (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ce,
  // programming port
  input wire logic prog_mode_pin,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // flash array side
  input wire logic iap_active,
  input wire logic mem_erase_done,
  output logic mem_erase_req,
  output logic [7:0] mem_fill,
  output logic mem_read_allow,
  output logic mem_write_allow,
  // halt and watchdog
  input wire logic halt_entry,
  input wire logic dog_active,
  output logic halt_reset,
  // decoded option byte 0
  output logic halt_reset_when_dog_active,
  output logic dog_software_enable_select,
  output logic dog_hw_enable,
  output obcd_pkg::obcd_vd_t voltage_detect_level,
  output logic low_supply_reset,
  output logic supply_warning_detector,
  output logic [1:0] first_block_size,
  output logic [12:0] first_block_bytes,
  output logic readout_lock,
  output logic program_lock,
  // decoded option byte 1
  output logic port_c_irq_vector_map,
  output logic clock_guard,
  output obcd_pkg::obcd_src_t clock_source_select,
  output logic [2:0] oscillator_band_select,
  output logic band_very_low_power,
  output logic band_two_to_four_mhz,
  output logic doubler_enable
);
  import obcd_pkg::*;

  logic prog_mode;
  logic prog_prev;
  logic load_pending;
  logic load;
  logic [7:0] opt0;
  logic [7:0] opt1;
  logic wr_opt0;
  logic wr_opt1;
  logic [7:0] cell_data0;
  logic [7:0] cell_data1;
  logic host_wr;
  logic opt_wr_hit;
  logic cmd_wr;
  logic live_wrlock;
  logic live_rdlock;
  logic refuse;
  logic refused;
  logic mem_clean;
  logic follow_opt;
  logic misuse;
  obcd_state_t state;
  obcd_state_t next_state;
  logic next_follow;

  // programming mode arrives on a pin
  obcd_sync3 #(.RESET_VAL(1'b0)) u_prog_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .ce(ce),
    .pin(prog_mode_pin),
    .level(prog_mode)
  );

  // the byte port only exists while programming mode is held
  assign host_wr = wr && prog_mode; // R1
  assign live_wrlock = opt0[B0_WRLOCK];
  assign live_rdlock = opt0[B0_RDLOCK];
  assign opt_wr_hit = host_wr && (addr == ADDR_OPT0 || addr == ADDR_OPT1);
  assign cmd_wr = host_wr && addr == ADDR_CMD && state == ST_IDLE;

  // write lock and mask parts refuse every change, busy refuses option writes
  assign refuse = (opt_wr_hit && (live_wrlock || MASK_ROM || state != ST_IDLE))
    || (cmd_wr && (wdata[CMD_ERASE_OPT] || wdata[CMD_ERASE_MEM])
    && (live_wrlock || MASK_ROM)); // R9 R17

  // option erase returns the shipped values so neither lock is left on
  always_comb begin
    wr_opt0 = 1'b0;
    wr_opt1 = 1'b0;
    cell_data0 = wdata;
    cell_data1 = wdata;
    if (state == ST_OPT_ERASE) begin
      wr_opt0 = 1'b1;
      wr_opt1 = 1'b1;
      cell_data0 = SHIP_OPT0;
      cell_data1 = SHIP_OPT1;
    end else if (opt_wr_hit && !refuse) begin
      wr_opt0 = addr == ADDR_OPT0;
      wr_opt1 = addr == ADDR_OPT1;
    end
  end

  // shipped contents select the RC oscillator; mask parts are fixed
  obcd_opt_cell #(
    .RESET_VAL(MASK_ROM ? MASK_OPT0 : SHIP_OPT0),
    .FIXED(MASK_ROM)
  ) u_cell0 (
    .clk_sys(clk_sys),
    .reset(reset),
    .ce(ce),
    .wr_en(wr_opt0),
    .wr_data(cell_data0),
    .rd_data(opt0)
  ); // R16 R17

  obcd_opt_cell #(
    .RESET_VAL(MASK_ROM ? MASK_OPT1 : SHIP_OPT1),
    .FIXED(MASK_ROM)
  ) u_cell1 (
    .clk_sys(clk_sys),
    .reset(reset),
    .ce(ce),
    .wr_en(wr_opt1),
    .wr_data(cell_data1),
    .rd_data(opt1)
  ); // R16 R17

  // erase sequencer: memory goes first whenever the read lock is on
  always_comb begin
    next_state = state;
    next_follow = follow_opt;
    unique case (state)
      ST_IDLE: begin
        if (cmd_wr && !refuse) begin
          if (wdata[CMD_ERASE_OPT]) begin
            next_follow = 1'b1;
            next_state = live_rdlock ? ST_MEM_ERASE : ST_OPT_ERASE; // R8
          end else if (wdata[CMD_ERASE_MEM]) begin
            next_follow = 1'b0;
            next_state = ST_MEM_ERASE;
          end
        end
      end
      ST_MEM_ERASE: begin
        if (mem_erase_done) begin
          next_state = follow_opt ? ST_OPT_ERASE : ST_IDLE; // R8
        end
      end
      ST_OPT_ERASE: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state <= ST_IDLE;
      follow_opt <= 1'b0;
      mem_erase_req <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      follow_opt <= next_follow;
      mem_erase_req <= next_state == ST_MEM_ERASE;
    end
  end

  // the array is told to fill with the erased pattern
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      mem_fill <= ERASED_BYTE; // R2
    end else if (ce) begin
      mem_fill <= ERASED_BYTE; // R2
    end
  end

  // sticky flags; a new event beats a clear in the same cycle
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      refused <= 1'b0;
      mem_clean <= 1'b0;
    end else if (ce) begin
      if (refuse) begin
        refused <= 1'b1;
      end else if (host_wr && addr == ADDR_STAT && wdata[STAT_REFUSED]) begin
        refused <= 1'b0;
      end
      if (state == ST_MEM_ERASE && mem_erase_done) begin
        mem_clean <= 1'b1;
      end else if (next_state == ST_MEM_ERASE) begin
        mem_clean <= 1'b0;
      end
    end
  end

  // read data stand one cycle only; outside programming mode they are zero
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rdata <= ZERO_BYTE;
    end else if (ce) begin
      rdata <= ZERO_BYTE;
      if (rd && prog_mode) begin // R1
        unique case (addr)
          ADDR_OPT0: rdata <= opt0;
          ADDR_OPT1: rdata <= opt1;
          ADDR_CMD: rdata <= ZERO_BYTE;
          ADDR_STAT: rdata <= {4'h0, misuse, mem_clean, refused, state != ST_IDLE};
        endcase
      end
    end
  end

  // protection acts on the live bytes, not on the held copy
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      mem_read_allow <= 1'b0;
      mem_write_allow <= 1'b0;
      halt_reset <= 1'b0;
    end else if (ce) begin
      mem_read_allow <= !live_rdlock || !prog_mode || iap_active; // R7
      mem_write_allow <= !live_wrlock && !MASK_ROM; // R9
      halt_reset <= halt_entry && dog_active && halt_reset_when_dog_active; // R3
    end
  end

  // sample once after reset and again when programming mode ends
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      load_pending <= 1'b1;
      prog_prev <= 1'b0;
    end else if (ce) begin
      load_pending <= 1'b0;
      prog_prev <= prog_mode;
    end
  end
  assign load = ce && (load_pending || (prog_prev && !prog_mode)); // R18

  // decoded byte 0, held between loads so the chip sees static levels
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      halt_reset_when_dog_active <= 1'b0;
      dog_software_enable_select <= 1'b0;
      dog_hw_enable <= 1'b1;
      voltage_detect_level <= VD_OFF;
      low_supply_reset <= 1'b0;
      supply_warning_detector <= 1'b0;
      first_block_size <= 2'h0;
      first_block_bytes <= BLOCK_BASE;
      readout_lock <= 1'b0;
      program_lock <= 1'b0;
    end else if (load) begin
      halt_reset_when_dog_active <= opt0[B0_HALT_RST]; // R3
      dog_software_enable_select <= opt0[B0_DOG_SW]; // R4
      dog_hw_enable <= !opt0[B0_DOG_SW]; // R4
      voltage_detect_level <= obcd_vd_t'(opt0[B0_VD_LO +: 2]); // R5
      low_supply_reset <= opt0[B0_VD_LO +: 2] != VD_OFF; // R5
      supply_warning_detector <= opt0[B0_VD_LO +: 2] != VD_OFF; // R5
      first_block_size <= opt0[B0_SEC_LO +: 2]; // R6
      first_block_bytes <= BLOCK_BASE << opt0[B0_SEC_LO +: 2]; // R6
      readout_lock <= opt0[B0_RDLOCK]; // R7
      program_lock <= opt0[B0_WRLOCK]; // R9
    end
  end

  // decoded byte 1
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      port_c_irq_vector_map <= 1'b1;
      clock_guard <= 1'b0;
      clock_source_select <= SRC_RC;
      oscillator_band_select <= 3'h7;
      band_very_low_power <= 1'b1;
      band_two_to_four_mhz <= 1'b0;
      doubler_enable <= 1'b0;
      misuse <= 1'b0;
    end else if (load) begin
      port_c_irq_vector_map <= opt1[B1_IRQ_MAP]; // R10
      clock_guard <= !opt1[B1_GUARD]; // R11
      clock_source_select <= obcd_src_t'(opt1[B1_SRC_LO +: 2]); // R12
      oscillator_band_select <= opt1[B1_BAND_LO +: 3]; // R13
      band_very_low_power <= opt1[B1_BAND_LO + 2]; // R13
      band_two_to_four_mhz <= opt1[B1_BAND_LO +: 3] == BAND_MP; // R13
      doubler_enable <= !opt1[B1_DOUBLER]; // R14
      // the doubler is still passed on; misuse is only reported
      misuse <= !opt1[B1_DOUBLER] && (opt1[B1_SRC_LO +: 2] == SRC_RC
        || opt1[B1_BAND_LO +: 3] != BAND_MP); // R15
    end
  end

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_mem_done;
    state == ST_MEM_ERASE && mem_erase_done && follow_opt && ce;
  endsequence
  sequence s_opt_then_idle;
    state == ST_OPT_ERASE ##1 state == ST_IDLE;
  endsequence

  a_opt_hidden: assert property ( // R1
    ce && rd && !prog_mode |=> rdata == ZERO_BYTE)
    else $error("option bytes readable outside programming mode");
  a_halt_reset: assert property ( // R3
    ce && halt_entry && dog_active && halt_reset_when_dog_active |=> halt_reset)
    else $error("halt entry gave no reset");
  a_dog_type: assert property ( // R4
    load && !reset |=> dog_hw_enable == !$past(opt0[B0_DOG_SW]))
    else $error("watchdog type wrong");
  a_vd_off: assert property ( // R5
    load && !reset && opt0[B0_VD_LO +: 2] == VD_OFF
    |=> !low_supply_reset && !supply_warning_detector)
    else $error("supply detection not off");
  a_block_size: assert property ( // R6
    load && !reset |=> first_block_bytes == (BLOCK_BASE << $past(opt0[B0_SEC_LO +: 2])))
    else $error("first block size wrong");
  a_read_block: assert property ( // R7
    ce && prog_mode && live_rdlock && !iap_active |=> !mem_read_allow)
    else $error("locked memory readable");
  a_erase_order: assert property ( // R8
    s_mem_done |=> s_opt_then_idle)
    else $error("option erase did not follow memory erase");
  a_lock_start: assert property ( // R8
    ce && cmd_wr && wdata[CMD_ERASE_OPT] && !refuse && live_rdlock |=> mem_erase_req)
    else $error("memory erase not first");
  a_write_lock: assert property ( // R9
    ce && opt_wr_hit && live_wrlock ##1 ce |=> opt0 == $past(opt0, 2))
    else $error("locked option byte changed");
  a_irq_map: assert property ( // R10
    load && !reset |=> port_c_irq_vector_map == $past(opt1[B1_IRQ_MAP]))
    else $error("irq map wrong");
  a_doubler: assert property ( // R14
    load && !reset |=> doubler_enable == !$past(opt1[B1_DOUBLER]))
    else $error("doubler wrong");
endmodule

// [verification/obcd_flash_model.sv]
// obcd_flash_model: flash array controller stand-in that answers erase requests.
// assumes mem_erase_req is a level held until done is seen; the bench sets the delay.
`timescale 1ns/10ps
module obcd_flash_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // erase handshake
  input wire logic mem_erase_req,
  input wire logic [7:0] erase_delay,
  output logic mem_erase_done
);
  logic [7:0] wait_count;
  // done pulses once and only while a request stands, so a late pulse cannot leak
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wait_count <= 8'h00;
      mem_erase_done <= 1'b0;
    end else if (mem_erase_req && !mem_erase_done && wait_count >= erase_delay) begin
      wait_count <= 8'h00;
      mem_erase_done <= 1'b1;
    end else begin
      mem_erase_done <= 1'b0;
      wait_count <= (mem_erase_req && !mem_erase_done) ? wait_count + 8'h01 : 8'h00;
    end
  end
endmodule

// [verification/tb_option_byte_config_decoder.sv]
// tb_option_byte_config_decoder: self-checking bench for the option byte decoder.
// assumes obcd_flash_model answers erases; the bench plays the programming tool.
`timescale 1ns/10ps
module tb_option_byte_config_decoder;
  import obcd_pkg::*;
  logic clk_sys, reset, prog_mode_pin, wr, rd, iap_active, halt_entry, dog_active;
  logic [1:0] addr;
  logic [7:0] wdata, rdata, mem_fill, v, b0, b1, nb0, nb1, erase_delay, rdata_m;
  logic mem_write_allow_m;
  logic mem_erase_req, mem_erase_done, mem_read_allow, mem_write_allow, halt_reset;
  logic halt_reset_when_dog_active, dog_software_enable_select, dog_hw_enable;
  logic low_supply_reset, supply_warning_detector, readout_lock, program_lock;
  logic port_c_irq_vector_map, clock_guard, band_very_low_power, band_two_to_four_mhz;
  logic doubler_enable;
  logic [1:0] first_block_size;
  logic [12:0] first_block_bytes;
  logic [2:0] oscillator_band_select;
  logic [31:0] lfsr_state;
  obcd_vd_t voltage_detect_level;
  obcd_src_t clock_source_select;
  int mismatches, num_checks;

  obcd_decoder dut (.clk_sys(clk_sys), .reset(reset), .ce(1'b1),
    .prog_mode_pin(prog_mode_pin), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .iap_active(iap_active), .mem_erase_done(mem_erase_done),
    .mem_erase_req(mem_erase_req), .mem_fill(mem_fill), .mem_read_allow(mem_read_allow),
    .mem_write_allow(mem_write_allow), .halt_entry(halt_entry), .dog_active(dog_active),
    .halt_reset(halt_reset), .halt_reset_when_dog_active(halt_reset_when_dog_active),
    .dog_software_enable_select(dog_software_enable_select), .dog_hw_enable(dog_hw_enable),
    .voltage_detect_level(voltage_detect_level), .low_supply_reset(low_supply_reset),
    .supply_warning_detector(supply_warning_detector), .first_block_size(first_block_size),
    .first_block_bytes(first_block_bytes), .readout_lock(readout_lock),
    .program_lock(program_lock), .port_c_irq_vector_map(port_c_irq_vector_map),
    .clock_guard(clock_guard), .clock_source_select(clock_source_select),
    .oscillator_band_select(oscillator_band_select),
    .band_very_low_power(band_very_low_power), .band_two_to_four_mhz(band_two_to_four_mhz),
    .doubler_enable(doubler_enable));

  // mask part beside the programmable one: same tool traffic, bytes fixed in hardware
  obcd_decoder #(.MASK_ROM(1'b1), .MASK_OPT1(8'hE9)) dut_mask (.clk_sys(clk_sys),
    .reset(reset), .ce(1'b1), .prog_mode_pin(prog_mode_pin), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata_m), .iap_active(iap_active), .mem_erase_done(1'b0),
    .mem_erase_req(), .mem_fill(), .mem_read_allow(), .mem_write_allow(mem_write_allow_m),
    .halt_entry(halt_entry), .dog_active(dog_active), .halt_reset(),
    .halt_reset_when_dog_active(), .dog_software_enable_select(), .dog_hw_enable(),
    .voltage_detect_level(), .low_supply_reset(), .supply_warning_detector(),
    .first_block_size(), .first_block_bytes(), .readout_lock(), .program_lock(),
    .port_c_irq_vector_map(), .clock_guard(), .clock_source_select(),
    .oscillator_band_select(), .band_very_low_power(), .band_two_to_four_mhz(),
    .doubler_enable());

  obcd_flash_model flash (.clk_sys(clk_sys), .reset(reset), .mem_erase_req(mem_erase_req),
    .erase_delay(erase_delay), .mem_erase_done(mem_erase_done));

  // free-running system clock, 25 ns period
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // one-cycle write strobe on the programming port
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe, so sample there
  task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // pin goes through a synchroniser, so give it time to settle and load
  task automatic set_prog(input logic m);
    @(posedge clk_sys);
    prog_mode_pin <= m;
    repeat (7) @(posedge clk_sys);
  endtask

  // every decoded field against the bench's own reading of both bytes
  task automatic check_fields(input logic [7:0] o0, input logic [7:0] o1);
    chk(halt_reset_when_dog_active, o0[7]);
    chk(dog_software_enable_select, o0[6]);
    chk(dog_hw_enable, !o0[6]);
    chk(voltage_detect_level, o0[5:4]);
    chk(low_supply_reset, o0[5:4] != 2'b11);
    chk(supply_warning_detector, o0[5:4] != 2'b11);
    chk(first_block_size, o0[3:2]);
    chk(first_block_bytes, 16'h0200 << o0[3:2]);
    chk(readout_lock, o0[1]);
    chk(program_lock, o0[0]);
    chk(port_c_irq_vector_map, o1[7]);
    chk(clock_guard, !o1[6]);
    chk(clock_source_select, o1[5:4]);
    chk(oscillator_band_select, o1[3:1]);
    chk(band_very_low_power, o1[3]);
    chk(band_two_to_four_mhz, o1[3:1] == 3'b001);
    chk(doubler_enable, !o1[0]);
  endtask

  // random halt and watchdog activity, reset pulse one cycle later
  task automatic halt_run(input logic en);
    logic ph;
    logic pd;
    ph = 1'b0;
    pd = 1'b0;
    repeat (12) begin
      @(posedge clk_sys);
      lfsr_state = lfsr_next(lfsr_state);
      halt_entry <= lfsr_state[0];
      dog_active <= lfsr_state[1];
      #1 chk(halt_reset, ph & pd & en);
      ph = lfsr_state[0];
      pd = lfsr_state[1];
    end
    @(posedge clk_sys);
    halt_entry <= 1'b0;
    dog_active <= 1'b0;
  endtask

  // issue an erase command, wait for the sequencer under a bounded poll
  task automatic erase_wait(input logic [7:0] cmd);
    wr_reg(ADDR_CMD, cmd);
    #1 chk(mem_erase_req, 1'b1);
    for (int k = 0; k < 40; k++) begin
      rd_reg(ADDR_STAT, v);
      if (v[STAT_BUSY] === 1'b0) break;
    end
    chk(v[STAT_BUSY], 1'b0);
    chk(v[STAT_MEM_CLEAN], 1'b1);
  endtask

  // hang guard, far beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    report_and_stop();
  end

  initial begin
    reset = 1'b1;
    prog_mode_pin = 1'b0;
    {wr, rd, iap_active, halt_entry, dog_active} = 5'h00;
    addr = 2'h0;
    wdata = 8'h00;
    erase_delay = 8'h00;
    mismatches = 0;
    num_checks = 0;
    lfsr_state = 32'hF0C7713D;
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 check_fields(SHIP_OPT0, SHIP_OPT1);
    chk(mem_fill, ERASED_BYTE);
    chk(mem_write_allow, 1'b1);
    chk(mem_write_allow_m, 1'b0);
    rd_reg(ADDR_OPT0, v);
    chk(v, ZERO_BYTE);
    wr_reg(ADDR_OPT0, 8'h00);
    set_prog(1'b1);
    rd_reg(ADDR_OPT0, v);
    chk(v, SHIP_OPT0);
    b0 = SHIP_OPT0;
    b1 = SHIP_OPT1;
    // eight passes cover every threshold, size, source and band code
    for (int i = 0; i < 8; i++) begin
      lfsr_state = lfsr_next(lfsr_state);
      nb0 = {i[0], lfsr_state[3], i[2:1], i[1:0], 2'b00};
      nb1 = {lfsr_state[4], lfsr_state[5], i[1:0], i[2:0], 1'b1};
      nb1[0] = (nb1[5:4] != 2'b10 && nb1[3:1] == 3'b001) ? lfsr_state[6] : 1'b1;
      wr_reg(ADDR_OPT0, nb0);
      wr_reg(ADDR_OPT1, nb1);
      rd_reg(ADDR_OPT1, v);
      chk(v, nb1);
      chk(rdata_m, 8'hE9);
      chk(first_block_size, b0[3:2]);
      chk(clock_source_select, b1[5:4]);
      set_prog(1'b0);
      b0 = nb0;
      b1 = nb1;
      #1 check_fields(b0, b1);
      halt_run(b0[7]);
      set_prog(1'b1);
      rd_reg(ADDR_STAT, v);
      chk(v[STAT_MISUSE], !b1[0] && (b1[5:4] == 2'b10 || b1[3:1] != 3'b001));
    end
    // read lock blocks access in programming mode unless in-application
    wr_reg(ADDR_OPT0, 8'hFE);
    repeat (2) @(posedge clk_sys);
    #1 chk(mem_read_allow, 1'b0);
    chk(readout_lock, b0[1]);
    @(posedge clk_sys);
    iap_active <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 chk(mem_read_allow, 1'b1);
    @(posedge clk_sys);
    iap_active <= 1'b0;
    // option erase under read lock goes through a slow memory erase first
    erase_delay <= 8'h09;
    erase_wait(8'h01);
    rd_reg(ADDR_OPT0, v);
    chk(v, SHIP_OPT0);
    erase_delay = 8'h00;
    erase_wait(8'h02);
    // write lock refuses option writes and erases until the next reset
    wr_reg(ADDR_OPT0, 8'hFD);
    repeat (2) @(posedge clk_sys);
    #1 chk(mem_write_allow, 1'b0);
    wr_reg(ADDR_OPT0, 8'hFC);
    wr_reg(ADDR_CMD, 8'h01);
    #1 chk(mem_erase_req, 1'b0);
    rd_reg(ADDR_STAT, v);
    chk(v[STAT_REFUSED], 1'b1);
    rd_reg(ADDR_OPT0, v);
    chk(v, 8'hFD);
    // a second reset reloads the shipped bytes
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 check_fields(SHIP_OPT0, SHIP_OPT1);
    report_and_stop();
  end
endmodule
